// >>> rtl/charge_status_pkg.sv
package charge_status_pkg;

    // Register map
    localparam logic [7:0] ADDR_CHG3   = 8'h01;
    localparam logic [7:0] ADDR_CHG2   = 8'h02;
    localparam logic [7:0] ADDR_CHG1   = 8'h03;
    localparam logic [7:0] ADDR_CHG0   = 8'h04;
    localparam logic [7:0] ADDR_MISC   = 8'h0F;
    localparam logic [7:0] ADDR_FAULT  = 8'h10;
    localparam logic [7:0] ADDR_EVENT  = 8'h11;
    localparam logic [7:0] ADDR_PROF_A = 8'h12;
    localparam logic [7:0] ADDR_PROF_B = 8'h13;
    localparam logic [7:0] ADDR_PINS   = 8'h14;

    // misc_status fields
    localparam int MISC_ALERT_BIT  = 5;
    localparam int MISC_ATTACH_BIT = 4;
    localparam int MISC_CHG_BIT    = 3;
    localparam int MISC_EMU_BIT    = 2;
    localparam int MISC_STEP_LSB   = 0;

    // fault_status fields
    localparam int FLT_ERR_BIT   = 7;
    localparam int FLT_DRAIN_BIT = 6;
    localparam int FLT_RESET_BIT = 5;
    localparam int FLT_UV_BIT    = 4;
    localparam int FLT_TSD_BIT   = 3;
    localparam int FLT_OV_BIT    = 2;
    localparam int FLT_REV_BIT   = 1;
    localparam int FLT_OC_BIT    = 0;
    localparam logic [7:0] FLT_COND_MASK = 8'h5F;
    localparam logic [7:0] FLT_RESET_VAL = 8'h20;

    // event_status fields
    localparam int EVT_BUDGET_BIT = 7;
    localparam int EVT_CC_BIT     = 4;
    localparam int EVT_THR_BIT    = 3;
    localparam int EVT_LOW_BIT    = 2;
    localparam int EVT_REM_BIT    = 1;
    localparam int EVT_ATT_BIT    = 0;
    localparam logic [7:0] EVT_RESET_VAL = 8'h00;

    // Meter geometry: 26 used bits, LSB in bit 6 of the low byte
    localparam int CHARGE_W     = 26;
    localparam int CUR_W        = 8;
    localparam int CHG0_USED_W  = 2;
    localparam int CHG0_PAD_W   = 6;

    // Timing
    localparam int CLK_HZ          = 100_000_000;
    localparam int METER_PERIOD_S  = 1;
    localparam int METER_CYC       = METER_PERIOD_S * CLK_HZ;

    // Current codes, one LSB per 9.76 mA
    localparam logic [7:0] CHG_DETECT_CODE = 8'h0A;
    localparam logic [7:0] LOW_DRAW_CODE   = 8'h01;
    localparam logic [7:0] OC_MIN_CODE     = 8'h0A;

    localparam logic [1:0] BUDGET_ACT_ALERT = 2'h1;
    localparam logic [1:0] STEP_NONE        = 2'h0;
    localparam logic [1:0] STEP_PAIR3       = 2'h3;

    localparam int SYNC_W = 8;

    typedef struct packed {
        logic drain_fail;
        logic bus_undervolt;
        logic over_temp;
        logic source_overvolt;
        logic reverse_volt;
        logic temp_regulate;
    } fault_cond_t;

    typedef struct packed {
        logic       running;
        logic [1:0] pair;
        logic       has_pair3;
    } emul_t;

    typedef enum {ST_RUN, ST_ERROR} err_state_t;

endpackage : charge_status_pkg

// >>> rtl/charge_meter.sv
`timescale 1ns/1ns
`default_nettype none
module charge_meter (
    // Clock and reset
    input  wire logic                                  clk_sys,
    input  wire logic                                  rst,
    // Control
    input  wire logic                                  tick,
    input  wire logic                                  active,
    input  wire logic                                  budget_en,
    input  wire logic                                  budget_clear,
    input  wire logic                                  snap_take,
    input  wire logic [charge_status_pkg::CUR_W-1:0]    cur,
    input  wire logic [charge_status_pkg::CHARGE_W-1:0] threshold,
    // Results
    output logic      [charge_status_pkg::CHARGE_W-1:0] total_r,
    output logic      [charge_status_pkg::CHARGE_W-1:0] snap_r,
    output logic                                        hit_r
);
    import charge_status_pkg::*;

    logic [CHARGE_W-1:0] total_nxt;
    logic [CHARGE_W-1:0] snap_nxt;
    logic                hit_nxt;
    logic [CHARGE_W:0]   sum;

    always_comb begin
        total_nxt = total_r;
        snap_nxt  = snap_r;
        hit_nxt   = 1'b0;
        sum       = {1'b0, total_r} + {{(CHARGE_W+1-CUR_W){1'b0}}, cur};
        if (budget_clear || !budget_en) begin
            total_nxt = '0; // R1
        end else if (tick && active) begin
            // Saturate rather than wrap, so the budget compare stays valid
            total_nxt = sum[CHARGE_W] ? '1 : sum[CHARGE_W-1:0]; // R3
            hit_nxt   = (total_nxt >= threshold); // R3
        end
        // Holding otherwise keeps the count through Sleep and Error
        if (snap_take) begin
            snap_nxt = total_r; // R25
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            total_r <= '0;
            snap_r  <= '0;
            hit_r   <= 1'b0;
        end else begin
            total_r <= total_nxt; // R2
            snap_r  <= snap_nxt;
            hit_r   <= hit_nxt;
        end
    end

endmodule : charge_meter
`default_nettype wire

// >>> rtl/charge_status_bank.sv
// Functional notes
// R1 - Meter zeroed only by clear or disable
// R2 - Meter kept outside Active, resumes later
// R3 - Active: update each second, compare threshold
// R4 - Four meter bytes, LSB bit 6 low
// R5 - Mirror alert and attach pin levels
// R6 - Charging flag follows current versus threshold
// R7 - Emulating flag only while Active and emulating
// R8 - Step field: none, pair one to three
// R9 - Error flag set; write zero rechecks faults
// R10 - Error auto-clears on recovery or disable
// R11 - Drain failure sets bit, alert, Error
// R12 - Fault bits clear on read if gone
// R13 - Bus undervoltage sets bit, alert, Error
// R14 - Thermal and source overvoltage faults likewise
// R15 - Reverse voltage fault sets bit, alert, Error
// R16 - Overcurrent needs limit and minimum trip
// R17 - Reset bit at power-up, no alert
// R18 - Budget reached bit, optional alert, clears
// R19 - Constant-current flag when over limit
// R20 - Throttle flag, read-clear, alert if linked
// R21 - Low-draw flag, read-clear, alert if linked
// R22 - Attach/removal flags drive attach pin
// R23 - Unmapped reads zero, writes ignored
// R24 - Reset loads every register default
// R25 - Coherent snapshot of meter bytes
`timescale 1ns/1ns
`default_nettype none
module charge_status_bank #(
    parameter int METER_CYCLES = charge_status_pkg::METER_CYC
) (
    // Clock and reset
    input  wire logic                                   clk_sys,
    input  wire logic                                   rst,
    // Register port
    input  wire logic [7:0]                             reg_addr,
    input  wire logic                                   reg_wr,
    input  wire logic                                   reg_rd,
    input  wire logic [7:0]                             reg_wdata,
    output logic      [7:0]                             reg_rdata,
    output logic                                        reg_rvalid,
    // Power state and configuration
    input  wire logic                                   pwr_active,
    input  wire logic                                   port_power_enable,
    input  wire logic                                   auto_recovery,
    input  wire logic                                   charge_budget_enable,
    input  wire logic                                   charge_budget_clear,
    input  wire logic [1:0]                             charge_budget_action,
    input  wire logic                                   alert_link,
    input  wire logic [charge_status_pkg::CHARGE_W-1:0]  budget_threshold,
    input  wire logic [7:0]                             current_limit_setting,
    // Measurement and detection
    input  wire logic [7:0]                             port_current,
    input  wire charge_status_pkg::fault_cond_t          fault_cond,
    input  wire logic                                   attach_event,
    input  wire logic                                   removal_event,
    input  wire charge_status_pkg::emul_t                emul,
    // Readback of neighbouring status
    input  wire logic [7:0]                             profile_result_a_in,
    input  wire logic [7:0]                             profile_result_b_in,
    input  wire logic [7:0]                             pin_state_in,
    // Open-drain pins
    input  wire logic                                   alert_pin_in,
    output logic                                        alert_pin_out,
    output logic                                        alert_pin_oe,
    input  wire logic                                   attach_detect_pin_in,
    output logic                                        attach_detect_pin_out,
    output logic                                        attach_detect_pin_oe,
    // To power switch
    output logic                                        error_state
);
    import charge_status_pkg::*;

    localparam logic [31:0] TICK_LAST = 32'(METER_CYCLES - 1);

    // Pin and comparator synchroniser
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    fault_cond_t       cond;
    logic              alert_pin_low;
    logic              attach_pin_low;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {~alert_pin_in, ~attach_detect_pin_in, fault_cond};
            sync2_r <= sync1_r;
        end
    end

    assign alert_pin_low  = sync2_r[SYNC_W-1];
    assign attach_pin_low = sync2_r[SYNC_W-2];
    assign cond           = fault_cond_t'(sync2_r[SYNC_W-3:0]);

    // One-second enable
    logic [31:0] tick_cnt_r;
    logic [31:0] tick_cnt_nxt;
    logic        tick;

    always_comb begin
        tick_cnt_nxt = (tick_cnt_r == TICK_LAST) ? '0 : tick_cnt_r + 32'h1;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    assign tick = (tick_cnt_r == TICK_LAST);

    // Access decode
    logic rd_fault;
    logic rd_event;
    logic wr_fault;
    logic snap_take;

    assign rd_fault  = reg_rd && (reg_addr == ADDR_FAULT);
    assign rd_event  = reg_rd && (reg_addr == ADDR_EVENT);
    assign wr_fault  = reg_wr && (reg_addr == ADDR_FAULT);
    assign snap_take = reg_rd && (reg_addr == ADDR_CHG3);

    // Charge meter
    err_state_t          state_r;
    logic [CHARGE_W-1:0] total;
    logic [CHARGE_W-1:0] snap;
    logic                budget_hit;

    charge_meter u_meter (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .tick         (tick),
        .active       (pwr_active && (state_r == ST_RUN)),
        .budget_en    (charge_budget_enable),
        .budget_clear (charge_budget_clear),
        .snap_take    (snap_take),
        .cur          (port_current),
        .threshold    (budget_threshold),
        .total_r      (total),
        .snap_r       (snap),
        .hit_r        (budget_hit)
    );

    // Fault status and error state
    err_state_t state_nxt;
    logic [7:0] fault_r;
    logic [7:0] fault_nxt;
    logic [7:0] cond_vec;
    logic       any_cond;
    logic       over_limit;
    logic       oc_cond;
    logic       en_prev_r;
    logic       recheck_ok;

    assign over_limit = port_current > current_limit_setting;
    assign oc_cond    = over_limit && (port_current > OC_MIN_CODE); // R16

    always_comb begin
        cond_vec                = '0;
        cond_vec[FLT_DRAIN_BIT] = cond.drain_fail; // R11
        cond_vec[FLT_UV_BIT]    = cond.bus_undervolt; // R13
        cond_vec[FLT_TSD_BIT]   = cond.over_temp; // R14
        cond_vec[FLT_OV_BIT]    = cond.source_overvolt; // R14
        cond_vec[FLT_REV_BIT]   = cond.reverse_volt; // R15
        cond_vec[FLT_OC_BIT]    = oc_cond; // R16
        any_cond                = |cond_vec;
        recheck_ok = !any_cond && !fault_r[FLT_RESET_BIT]; // R9
        state_nxt  = state_r;
        fault_nxt  = fault_r;
        if (rd_fault) begin
            fault_nxt = fault_nxt & ~(FLT_COND_MASK & ~cond_vec); // R12
            fault_nxt[FLT_RESET_BIT] = 1'b0; // R17
        end
        if (port_power_enable != en_prev_r) begin
            fault_nxt[FLT_RESET_BIT] = 1'b0; // R17
        end
        if (state_r == ST_ERROR) begin
            if ((wr_fault && !reg_wdata[FLT_ERR_BIT] && recheck_ok) // R9
                || (auto_recovery && !any_cond) // R10
                || !port_power_enable) begin // R10
                state_nxt = ST_RUN;
                fault_nxt = fault_nxt & ~FLT_COND_MASK; // R12
            end
        end
        // A fault present in a clearing cycle still wins
        fault_nxt = fault_nxt | cond_vec; // R11
        if (any_cond) begin
            state_nxt = ST_ERROR; // R9
        end
        fault_nxt[FLT_ERR_BIT] = 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r   <= ST_RUN;
            fault_r   <= FLT_RESET_VAL; // R17
            en_prev_r <= port_power_enable;
        end else begin
            state_r   <= state_nxt;
            fault_r   <= fault_nxt;
            en_prev_r <= port_power_enable;
        end
    end

    // Event status
    logic [7:0] evt_r;
    logic [7:0] evt_nxt;
    logic       low_prev_r;
    logic       low_now;
    logic       att_pin_r;
    logic       att_pin_nxt;

    assign low_now = port_current < LOW_DRAW_CODE;

    always_comb begin
        evt_nxt     = evt_r;
        att_pin_nxt = att_pin_r;
        if (rd_event) begin
            evt_nxt = '0; // R20
        end
        if (charge_budget_clear || !charge_budget_enable) begin
            evt_nxt[EVT_BUDGET_BIT] = 1'b0; // R18
        end
        if (budget_hit && charge_budget_enable) begin
            evt_nxt[EVT_BUDGET_BIT] = 1'b1; // R18
        end
        if (over_limit) begin
            evt_nxt[EVT_CC_BIT] = 1'b1; // R19
        end
        if (cond.temp_regulate) begin
            evt_nxt[EVT_THR_BIT] = 1'b1; // R20
        end
        if (low_now && !low_prev_r) begin
            evt_nxt[EVT_LOW_BIT] = 1'b1; // R21
        end
        if (removal_event) begin
            evt_nxt[EVT_REM_BIT] = 1'b1; // R22
            att_pin_nxt          = 1'b0; // R22
        end
        if (attach_event) begin
            evt_nxt[EVT_ATT_BIT] = 1'b1; // R22
            att_pin_nxt          = 1'b1; // R22
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            evt_r      <= EVT_RESET_VAL;
            low_prev_r <= 1'b1;
            att_pin_r  <= 1'b0;
        end else begin
            evt_r      <= evt_nxt;
            low_prev_r <= low_now;
            att_pin_r  <= att_pin_nxt;
        end
    end

    // Alert pin: reset bit and attach events never drive it
    logic alert_nxt;
    logic budget_alert;
    logic linked_alert;

    assign budget_alert = evt_r[EVT_BUDGET_BIT]
                          && (charge_budget_action == BUDGET_ACT_ALERT); // R18
    assign linked_alert = alert_link
                          && (evt_r[EVT_THR_BIT] || evt_r[EVT_LOW_BIT]); // R21

    always_comb begin
        alert_nxt = (|(fault_r & FLT_COND_MASK)) // R13
                    || budget_alert || linked_alert; // R20
    end

    // Misc status, sampled into a register
    logic [7:0] misc_r;
    logic [7:0] misc_nxt;
    logic       emulating;

    always_comb begin
        emulating = pwr_active && (state_r == ST_RUN) && emul.running; // R7
        misc_nxt  = '0;
        misc_nxt[MISC_ALERT_BIT]  = alert_pin_low; // R5
        misc_nxt[MISC_ATTACH_BIT] = attach_pin_low; // R5
        misc_nxt[MISC_CHG_BIT]    = port_current > CHG_DETECT_CODE; // R6
        misc_nxt[MISC_EMU_BIT]    = emulating; // R7
        if (emulating && !(emul.pair == STEP_PAIR3 && !emul.has_pair3)) begin
            misc_nxt[MISC_STEP_LSB +: 2] = emul.pair; // R8
        end else begin
            misc_nxt[MISC_STEP_LSB +: 2] = STEP_NONE; // R8
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            misc_r <= '0;
        end else begin
            misc_r <= misc_nxt;
        end
    end

    // Read data path
    logic [7:0] rdata_nxt;
    logic [7:0] fault_view;

    always_comb begin
        fault_view              = fault_r;
        fault_view[FLT_ERR_BIT] = (state_r == ST_ERROR); // R9
        rdata_nxt               = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CHG3:   rdata_nxt = total[CHARGE_W-1 -: 8]; // R4
                ADDR_CHG2:   rdata_nxt = snap[CHARGE_W-9 -: 8]; // R25
                ADDR_CHG1:   rdata_nxt = snap[CHARGE_W-17 -: 8]; // R25
                ADDR_CHG0:   rdata_nxt = {snap[CHG0_USED_W-1:0],
                                          {CHG0_PAD_W{1'b0}}}; // R4
                ADDR_MISC:   rdata_nxt = misc_r;
                ADDR_FAULT:  rdata_nxt = fault_view;
                ADDR_EVENT:  rdata_nxt = evt_r;
                ADDR_PROF_A: rdata_nxt = profile_result_a_in;
                ADDR_PROF_B: rdata_nxt = profile_result_b_in;
                ADDR_PINS:   rdata_nxt = pin_state_in;
                default:     rdata_nxt = '0; // R23
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata             <= '0; // R24
            reg_rvalid            <= 1'b0;
            alert_pin_out         <= 1'b0;
            alert_pin_oe          <= 1'b0;
            attach_detect_pin_out <= 1'b0;
            attach_detect_pin_oe  <= 1'b0;
            error_state           <= 1'b0;
        end else begin
            reg_rdata             <= rdata_nxt;
            reg_rvalid            <= reg_rd;
            alert_pin_out         <= 1'b0;
            alert_pin_oe          <= alert_nxt; // R11
            attach_detect_pin_out <= 1'b0;
            attach_detect_pin_oe  <= att_pin_nxt; // R22
            error_state           <= (state_nxt == ST_ERROR); // R9
        end
    end

endmodule : charge_status_bank
`default_nettype wire

// >>> test/portable_device_model.sv
`timescale 1ns/1ns
`default_nettype none
module portable_device_model (
    // Clock
    input  wire logic       clk_sys,
    // Bench control
    input  wire logic       plugged,
    input  wire logic [7:0] load,
    // Port side
    output logic            attach_event,
    output logic            removal_event,
    output logic      [7:0] port_current
);
    logic plugged_r = 1'b0;
    always_ff @(posedge clk_sys) begin
        plugged_r <= plugged;
    end
    // One-cycle plug and unplug events
    assign attach_event  = plugged & ~plugged_r;
    assign removal_event = ~plugged & plugged_r;
    // No draw without a device on the port
    assign port_current  = plugged_r ? load : 8'h00;
endmodule : portable_device_model
`default_nettype wire

// >>> test/charge_status_bank_chk.sv
`timescale 1ns/1ns
`default_nettype none
module charge_status_bank_chk (
    // Clock and reset
    input wire logic                       clk_sys,
    input wire logic                       rst,
    // Register port
    input wire logic                       reg_rd,
    input wire logic [7:0]                 reg_addr,
    input wire logic [7:0]                 reg_rdata,
    input wire logic                       reg_rvalid,
    // Conditions
    input wire logic                       port_power_enable,
    input wire logic [7:0]                 port_current,
    input wire logic [7:0]                 current_limit_setting,
    input wire charge_status_pkg::fault_cond_t fault_cond,
    input wire logic                       attach_event,
    input wire logic                       removal_event,
    // Outputs
    input wire logic                       alert_pin_out,
    input wire logic                       alert_pin_oe,
    input wire logic                       attach_detect_pin_out,
    input wire logic                       attach_detect_pin_oe,
    input wire logic                       error_state
);
    import charge_status_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_unmapped; reg_rd && reg_addr == 8'h05 |=> reg_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_reset; disable iff (1'b0)
        rst |=> !reg_rvalid && !error_state && !alert_pin_oe && !attach_detect_pin_oe;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    property p_att; attach_event |=> attach_detect_pin_oe; endproperty
    a_att: assert property (p_att) else $error("attach pin not asserted");
    property p_rem; removal_event |=> !attach_detect_pin_oe; endproperty
    a_rem: assert property (p_rem) else $error("attach pin not released");
    property p_odrain; alert_pin_out == 1'b0 && attach_detect_pin_out == 1'b0; endproperty
    a_odrain: assert property (p_odrain) else $error("open-drain data not low");
    property p_fault; fault_cond[5:1] != 5'h00 [*2] |-> ##[1:4] error_state; endproperty
    a_fault: assert property (p_fault) else $error("fault without Error");
    property p_alert; $rose(error_state) |-> ##[0:2] alert_pin_oe; endproperty
    a_alert: assert property (p_alert) else $error("Error without alert");
    property p_oc;
        (port_current > current_limit_setting && port_current > OC_MIN_CODE) [*2]
            |-> ##[0:3] error_state;
    endproperty
    a_oc: assert property (p_oc) else $error("overcurrent without Error");
    property p_pwroff;
        (!port_power_enable && fault_cond == 6'h00 && port_current <= current_limit_setting)
            [*4] |=> !error_state;
    endproperty
    a_pwroff: assert property (p_pwroff) else $error("Error kept with power off");
    c_err: cover property ($rose(error_state));
    c_att: cover property (attach_event);
    c_budget: cover property (reg_rvalid && reg_rdata[7]);
endmodule : charge_status_bank_chk
bind charge_status_bank charge_status_bank_chk chk_u (.*);
`default_nettype wire

// >>> test/tb_charge_status_bank.sv
`timescale 1ns/1ns
`default_nettype none
module tb_charge_status_bank;
    import charge_status_pkg::*;
    localparam logic [7:0] RA [13] = '{ADDR_CHG3, ADDR_CHG2, ADDR_CHG1, ADDR_CHG0, ADDR_MISC,
        ADDR_EVENT, ADDR_PROF_A, ADDR_PROF_B, ADDR_PINS, 8'h05, 8'h20, ADDR_FAULT, ADDR_FAULT};
    localparam logic [7:0] RE [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'hA5, 8'h5A, 8'h3C, 8'h00, 8'h00, 8'h20, 8'h00};
    localparam logic [5:0] FC [5] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02};
    localparam logic [7:0] FE [5] = '{8'hC0, 8'h90, 8'h88, 8'h84, 8'h82};
    logic                clk_sys = 1'b0;
    logic                rst = 1'b1;
    logic [7:0]          reg_addr = 8'h00;
    logic                reg_wr = 1'b0;
    logic                reg_rd = 1'b0;
    logic [7:0]          reg_wdata = 8'h00;
    logic [7:0]          reg_rdata;
    logic                reg_rvalid;
    logic                pwr_active = 1'b0;
    logic                port_power_enable = 1'b1;
    logic                auto_recovery = 1'b0;
    logic                alert_link = 1'b0;
    logic                charge_budget_enable = 1'b0;
    logic                charge_budget_clear = 1'b0;
    logic [1:0]          charge_budget_action = BUDGET_ACT_ALERT;
    logic [CHARGE_W-1:0] budget_threshold = 26'h30;
    logic [7:0]          current_limit_setting = 8'hFF;
    fault_cond_t         fault_cond = '0;
    emul_t               emul = '0;
    logic                plugged = 1'b0;
    logic                attach_event;
    logic                removal_event;
    logic [7:0]          port_current;
    logic                alert_pin_out;
    logic                alert_pin_oe;
    logic                attach_detect_pin_out;
    logic                attach_detect_pin_oe;
    logic                error_state;
    logic [7:0]          rv;
    int                  errors = 0;
    int                  n_compared = 0;
    // Open-drain lines with pull-ups
    wire                 alert_pin = alert_pin_oe ? 1'b0 : 1'b1;
    wire                 attach_pin_mirror = attach_detect_pin_oe ? 1'b0 : 1'b1;

    always #5 clk_sys = ~clk_sys;

    charge_status_bank #(.METER_CYCLES(20)) dut_u (
        .*, .profile_result_a_in(8'hA5),
        .profile_result_b_in(8'h5A), .pin_state_in(8'h3C), .alert_pin_in(alert_pin),
        .attach_detect_pin_in(attach_pin_mirror));
    portable_device_model dev_u (.clk_sys(clk_sys), .plugged(plugged), .load(8'h10),
        .attach_event(attach_event), .removal_event(removal_event), .port_current(port_current));

    task automatic end_sim;
        $display("compared=%0d errors=%0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rvalid ? reg_rdata : 'x;
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        rd(a, rv);
        check(rv, exp);
    endtask : rdc
    // High byte first so the lower bytes come from one snapshot
    task automatic meter(input logic [25:0] v);
        logic [31:0] w;
        w = {v, 6'h00};
        for (int i = 0; i < 4; i++) begin
            rdc(ADDR_CHG3 + 8'(i), w[31-8*i -: 8]);
        end
    endtask : meter
    task automatic wait_lvl(input logic alert, input logic v);
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge clk_sys);
            if ((alert ? alert_pin_oe : error_state) === v) break;
        end
        if (i == 300) begin
            errors++;
            end_sim();
        end
    endtask : wait_lvl

    initial begin
        cyc(3);
        rst <= 1'b0;
        cyc(3);
        foreach (RA[i]) rdc(RA[i], RE[i]);
        wr(ADDR_MISC, 8'hFF);
        wr(8'h05, 8'hFF);
        rdc(ADDR_MISC, 8'h00);
        rdc(8'h05, 8'h00);
        plugged <= 1'b1;
        cyc(6);
        rdc(ADDR_EVENT, 8'h01);
        rdc(ADDR_EVENT, 8'h00);
        rdc(ADDR_MISC, 8'h18);
        pwr_active <= 1'b1;
        emul       <= '{1'b1, 2'h2, 1'b1};
        cyc(4);
        rdc(ADDR_MISC, 8'h1E);
        emul <= '{1'b1, 2'h3, 1'b0};
        cyc(4);
        rdc(ADDR_MISC, 8'h1C);
        pwr_active <= 1'b0;
        cyc(4);
        rdc(ADDR_MISC, 8'h18);
        emul                 <= '0;
        pwr_active           <= 1'b1;
        charge_budget_enable <= 1'b1;
        wait_lvl(1'b1, 1'b1);
        pwr_active <= 1'b0;
        meter(26'h30);
        rdc(ADDR_EVENT, 8'h80);
        cyc(4);
        check({7'h0, alert_pin_oe}, 8'h00);
        cyc(40);
        meter(26'h30);
        pwr_active <= 1'b1;
        cyc(45);
        pwr_active <= 1'b0;
        for (int i = 0; i < 3; i++) rd(ADDR_CHG3 + 8'(i), rv);
        check({7'h0, rv > 8'h0C}, 8'h01);
        charge_budget_clear <= 1'b1;
        cyc(1);
        charge_budget_clear  <= 1'b0;
        charge_budget_enable <= 1'b0;
        meter(26'h0);
        rdc(ADDR_EVENT, 8'h00);
        for (int k = 0; k < 5; k++) begin
            fault_cond <= FC[k];
            wait_lvl(1'b0, 1'b1);
            cyc(5);
            rdc(ADDR_MISC, 8'h38);
            rdc(ADDR_FAULT, FE[k]);
            fault_cond <= '0;
            cyc(4);
            rdc(ADDR_FAULT, FE[k]);
            rdc(ADDR_FAULT, 8'h80);
            wr(ADDR_FAULT, 8'h00);
            cyc(3);
            check({7'h0, error_state}, 8'h00);
        end
        current_limit_setting <= 8'h0C;
        wait_lvl(1'b0, 1'b1);
        rdc(ADDR_FAULT, 8'h81);
        rdc(ADDR_EVENT, 8'h10);
        current_limit_setting <= 8'hFF;
        rd(ADDR_EVENT, rv);
        port_power_enable <= 1'b0;
        cyc(7);
        check({7'h0, error_state}, 8'h00);
        port_power_enable <= 1'b1;
        plugged           <= 1'b0;
        alert_link        <= 1'b1;
        cyc(6);
        check({7'h0, alert_pin_oe}, 8'h01);
        rdc(ADDR_EVENT, 8'h06);
        check({7'h0, attach_detect_pin_oe}, 8'h00);
        auto_recovery <= 1'b1;
        fault_cond    <= 6'h04;
        wait_lvl(1'b0, 1'b1);
        fault_cond <= '0;
        wait_lvl(1'b0, 1'b0);
        end_sim();
    end
endmodule : tb_charge_status_bank
`default_nettype wire
